// file: inc/mmdec_pkg.sv
package mmdec_pkg;

    // ------------------------------------------------------------
    // Address space and variants
    // ------------------------------------------------------------
    localparam int ADDR_W = 20;

    typedef enum logic [1:0] {
        MMDEC_SMALL,
        MMDEC_MIDDLE,
        MMDEC_LARGE
    } mmdec_variant_t;

    typedef enum logic [1:0] {
        MMDEC_TGT_NONE,
        MMDEC_TGT_ROM,
        MMDEC_TGT_DATA,
        MMDEC_TGT_EXT
    } mmdec_target_t;

    typedef struct packed {
        mmdec_target_t     target;
        logic              sfr;
        logic [ADDR_W-1:0] offset;
    } mmdec_result_t;

    // ------------------------------------------------------------
    // Region bounds
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] DATA_LO_SMALL  = 20'h0f100;
    localparam logic [ADDR_W-1:0] DATA_LO_MIDDLE = 20'h0eb00;
    localparam logic [ADDR_W-1:0] DATA_LO_LARGE  = 20'h0df00;
    localparam logic [ADDR_W-1:0] DATA_HI_SMALL  = 20'hff100;
    localparam logic [ADDR_W-1:0] DATA_HI_MIDDLE = 20'hfeb00;
    localparam logic [ADDR_W-1:0] DATA_HI_LARGE  = 20'hfdf00;
    localparam logic [ADDR_W-1:0] DATA_LO_END    = 20'h0ffff;
    localparam logic [ADDR_W-1:0] DATA_HI_END    = 20'hfffff;
    localparam logic [ADDR_W-1:0] ROM_BASE       = 20'h00000;
    localparam logic [ADDR_W-1:0] ROM2_BASE      = 20'h10000;
    localparam logic [ADDR_W-1:0] ROM_END_SMALL  = 20'h17fff;
    localparam logic [ADDR_W-1:0] ROM_END_OTHER  = 20'h1ffff;
    localparam logic [ADDR_W-1:0] SFR_LO_BASE    = 20'h0ff00;
    localparam logic [ADDR_W-1:0] SFR_HI_BASE    = 20'hfff00;
    localparam logic [ADDR_W-1:0] VECTOR_END     = 20'h000ff;

    // Placement codes of the placement instruction operand
    localparam logic [3:0] PLACE_LOW_CODE  = 4'h0;
    localparam logic [3:0] PLACE_HIGH_CODE = 4'hf;
    localparam logic       PLACED_RESET    = 1'b0;
    localparam logic       HIGH_RESET      = 1'b0;

endpackage

// file: core/mmdec_top.sv
`timescale 1ns/1ns
module mmdec_top
    import mmdec_pkg::*;
#(
    parameter mmdec_variant_t VARIANT = MMDEC_LARGE
) (
    input  wire logic              MCLK,
    input  wire logic              RST,
    input  wire logic              PLACE_VALID,
    input  wire logic [3:0]        PLACE_CODE,
    input  wire logic              EXP_MODE,
    input  wire logic              ACC_VALID,
    input  wire logic [ADDR_W-1:0] ACC_ADDR,
    output logic                   PLACED,
    output logic                   HIGH_PLACE,
    output logic                   RES_VALID,
    output mmdec_result_t          RESULT,
    output logic                   VECTOR_HIT
);

    // ------------------------------------------------------------
    // Variant bounds
    // ------------------------------------------------------------
    wire logic [ADDR_W-1:0] data_lo_base =
        (VARIANT == MMDEC_SMALL)  ? DATA_LO_SMALL  :
        (VARIANT == MMDEC_MIDDLE) ? DATA_LO_MIDDLE : DATA_LO_LARGE;
    wire logic [ADDR_W-1:0] data_hi_base =
        (VARIANT == MMDEC_SMALL)  ? DATA_HI_SMALL  :
        (VARIANT == MMDEC_MIDDLE) ? DATA_HI_MIDDLE : DATA_HI_LARGE;
    wire logic [ADDR_W-1:0] rom_end =
        (VARIANT == MMDEC_SMALL) ? ROM_END_SMALL : ROM_END_OTHER;

    function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] lo,
                                      input logic [ADDR_W-1:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // ------------------------------------------------------------
    // Placement latch
    // ------------------------------------------------------------
    logic placed_reg;
    logic high_reg;
    wire logic take_place = PLACE_VALID && !placed_reg;
    wire logic code_high  = (PLACE_CODE == PLACE_HIGH_CODE);

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            placed_reg <= PLACED_RESET;
            high_reg   <= HIGH_RESET;
        end else if (take_place) begin
            placed_reg <= 1'b1;
            high_reg   <= code_high;
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Before placement the low map is used, so vectors stay in ROM
    wire logic [ADDR_W-1:0] data_base = high_reg ? data_hi_base
                                                 : data_lo_base;
    wire logic [ADDR_W-1:0] data_end  = high_reg ? DATA_HI_END
                                                 : DATA_LO_END;
    wire logic [ADDR_W-1:0] sfr_base  = high_reg ? SFR_HI_BASE
                                                 : SFR_LO_BASE;
    wire logic hit_data = in_range(ACC_ADDR, data_base, data_end);
    wire logic hit_sfr  = in_range(ACC_ADDR, sfr_base, data_end);
    // low map splits ROM around the data area
    wire logic hit_rom  = in_range(ACC_ADDR, ROM_BASE, rom_end);
    // data wins over the ROM it overlaps
    wire logic [1:0] tgt_sel = {hit_data, hit_rom};
    mmdec_target_t tgt;
    always_comb begin
        unique case (tgt_sel)
            2'b10, 2'b11: tgt = MMDEC_TGT_DATA;
            2'b01:        tgt = MMDEC_TGT_ROM;
            default:      tgt = EXP_MODE ? MMDEC_TGT_EXT
                                         : MMDEC_TGT_NONE;
        endcase
    end
    wire logic [ADDR_W-1:0] offs = (tgt == MMDEC_TGT_DATA)
                                   ? ACC_ADDR - data_base : ACC_ADDR;
    // vector base lies in ROM in both placements
    wire logic vec_hit = in_range(ACC_ADDR, ROM_BASE, VECTOR_END);

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            RES_VALID  <= 1'b0;
            RESULT     <= '0;
            VECTOR_HIT <= 1'b0;
        end else begin
            RES_VALID  <= ACC_VALID;
            RESULT     <= '{target: tgt, sfr: hit_sfr, offset: offs};
            VECTOR_HIT <= ACC_VALID && vec_hit;
        end
    end

    assign PLACED     = placed_reg;
    assign HIGH_PLACE = high_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    place_hold_a: assert property (placed_reg |=>
        placed_reg && $stable(high_reg))
        else $error("placement changed after latch");
    place_take_a: assert property (PLACE_VALID && !placed_reg |=>
        placed_reg && high_reg == $past(code_high))
        else $error("placement not latched");
    data_low_a: assert property (ACC_VALID && !high_reg &&
        ACC_ADDR >= data_lo_base && ACC_ADDR <= DATA_LO_END
        |=> RESULT.target == MMDEC_TGT_DATA)
        else $error("low data area missed");
    overlap_a: assert property (ACC_VALID && !high_reg &&
        hit_rom && hit_data |=> RESULT.target == MMDEC_TGT_DATA)
        else $error("overlap not steered to data");
    data_high_a: assert property (ACC_VALID && high_reg &&
        ACC_ADDR >= data_hi_base |=> RESULT.target == MMDEC_TGT_DATA)
        else $error("high data area missed");
    rom_high_a: assert property (ACC_VALID && high_reg &&
        ACC_ADDR <= rom_end |=> RESULT.target == MMDEC_TGT_ROM)
        else $error("high rom region missed");
    rom_low_a: assert property (ACC_VALID && !high_reg &&
        ACC_ADDR < data_lo_base |=> RESULT.target == MMDEC_TGT_ROM)
        else $error("low rom region missed");
    ext_gate_a: assert property (ACC_VALID && !hit_rom &&
        !hit_data |=> RESULT.target == ($past(EXP_MODE)
        ? MMDEC_TGT_EXT : MMDEC_TGT_NONE))
        else $error("external steering wrong");
    sfr_win_a: assert property (ACC_VALID &&
        ACC_ADDR >= sfr_base && ACC_ADDR <= data_end |=> RESULT.sfr)
        else $error("register window missed");
    vec_rom_a: assert property (ACC_VALID && vec_hit |=>
        VECTOR_HIT && RESULT.target == MMDEC_TGT_ROM)
        else $error("vector area not in rom");

    // ------------------------------------------------------------
    // Boundary and handshake checks
    // ------------------------------------------------------------
    valid_rise_a: assert property (ACC_VALID |=>
        RES_VALID)
        else $error("result valid missing");
    valid_fall_a: assert property (!ACC_VALID |=>
        !RES_VALID)
        else $error("result valid without access");
    ext_inside_a: assert property (ACC_VALID &&
        ACC_ADDR <= rom_end |=> RESULT.target != MMDEC_TGT_EXT)
        else $error("rom address sent outside");
    low_map_a: assert property (!placed_reg |->
        !high_reg)
        else $error("high map before placement");
    late_keep_a: assert property (PLACE_VALID && placed_reg |=>
        high_reg == $past(high_reg))
        else $error("late placement taken");
    rom_lo_end_a: assert property (ACC_VALID && !high_reg &&
        ACC_ADDR == data_lo_base - 20'h1 |=> RESULT.target == MMDEC_TGT_ROM)
        else $error("last low rom byte missed");
    rom2_low_a: assert property (ACC_VALID && !high_reg &&
        ACC_ADDR >= ROM2_BASE && ACC_ADDR <= rom_end
        |=> RESULT.target == MMDEC_TGT_ROM)
        else $error("second rom region missed");
    rom_offset_a: assert property (ACC_VALID && hit_rom && !hit_data |=>
        RESULT.offset == $past(ACC_ADDR))
        else $error("rom offset not raw");
    hid_rom_a: assert property (ACC_VALID && high_reg &&
        ACC_ADDR >= data_lo_base && ACC_ADDR <= DATA_LO_END
        |=> RESULT.target == MMDEC_TGT_ROM)
        else $error("hidden rom not reachable");
    low_no_hi_a: assert property (ACC_VALID && !high_reg &&
        ACC_ADDR >= data_hi_base |=> RESULT.target != MMDEC_TGT_DATA)
        else $error("high area decoded in low map");
    // Area size is the same in both placements
    data_size_a: assert property (ACC_VALID && hit_data |=>
        RESULT.offset <= DATA_LO_END - data_lo_base)
        else $error("data offset beyond area");
    data_base_a: assert property (ACC_VALID &&
        ACC_ADDR == data_base |=> RESULT.offset == '0)
        else $error("area base offset not zero");
    data_end_a: assert property (ACC_VALID &&
        ACC_ADDR == data_end |=> RESULT.target == MMDEC_TGT_DATA
        && RESULT.sfr)
        else $error("area end not a register");
    low_sfr_a: assert property (ACC_VALID && !high_reg &&
        ACC_ADDR >= SFR_LO_BASE && ACC_ADDR <= DATA_LO_END |=> RESULT.sfr)
        else $error("low register window missed");
    high_sfr_a: assert property (ACC_VALID && high_reg &&
        ACC_ADDR >= SFR_HI_BASE |=> RESULT.sfr)
        else $error("high register window missed");
    sfr_only_a: assert property (ACC_VALID &&
        ACC_ADDR < sfr_base |=> !RESULT.sfr)
        else $error("register flag outside window");
    sfr_data_a: assert property (ACC_VALID && hit_sfr |=>
        RESULT.target == MMDEC_TGT_DATA)
        else $error("register window not in data");
    ext_off_a: assert property (ACC_VALID && !EXP_MODE |=>
        RESULT.target != MMDEC_TGT_EXT)
        else $error("external access without expansion");
    ext_on_a: assert property (ACC_VALID && EXP_MODE &&
        ACC_ADDR > rom_end && !hit_data |=> RESULT.target == MMDEC_TGT_EXT)
        else $error("expansion access not external");
    none_off_a: assert property (ACC_VALID && !EXP_MODE &&
        ACC_ADDR > rom_end && !hit_data |=> RESULT.target == MMDEC_TGT_NONE)
        else $error("unmapped access not dropped");
    low_gap_a: assert property (ACC_VALID && !high_reg &&
        ACC_ADDR > rom_end |=> RESULT.target != MMDEC_TGT_ROM
        && RESULT.target != MMDEC_TGT_DATA)
        else $error("low map gap decoded inside");
    high_gap_a: assert property (ACC_VALID && high_reg &&
        ACC_ADDR > rom_end && ACC_ADDR < data_hi_base |=>
        RESULT.target != MMDEC_TGT_ROM && RESULT.target != MMDEC_TGT_DATA)
        else $error("high map gap decoded inside");
    vec_gate_a: assert property (!ACC_VALID |=>
        !VECTOR_HIT)
        else $error("vector flag without access");
    vec_none_a: assert property (ACC_VALID &&
        ACC_ADDR > VECTOR_END |=> !VECTOR_HIT)
        else $error("vector flag outside base area");
    vec_addr_a: assert property (VECTOR_HIT |->
        RESULT.offset <= VECTOR_END && RESULT.target == MMDEC_TGT_ROM)
        else $error("vector flag with wrong address");
    vec_base_a: assert property (ACC_VALID &&
        ACC_ADDR == ROM_BASE |=> VECTOR_HIT)
        else $error("reset entry not flagged");

    place_low_c:  cover property (take_place && !code_high);
    place_high_c: cover property (take_place && code_high);
    late_place_c: cover property (PLACE_VALID && placed_reg);
    ext_acc_c:    cover property (ACC_VALID && tgt == MMDEC_TGT_EXT);
    vec_acc_c:    cover property (ACC_VALID && vec_hit);

endmodule

// file: testbench/mmdec_cpu_model.sv
`timescale 1ns/1ns
module mmdec_cpu_model
    import mmdec_pkg::*;
(
    input  wire logic          MCLK,
    output logic               place_valid,
    output logic [3:0]         place_code,
    output logic               acc_valid,
    output logic [ADDR_W-1:0]  acc_addr
);
    initial begin
        place_valid = 1'h0;
        place_code  = 4'h5;
        acc_valid   = 1'h0;
        acc_addr    = 20'h5a5a5;
    end

    // Caller issues a placement after each reset, two after the mid-run one
    task automatic place(input logic [3:0] code);
        @(negedge MCLK);
        place_valid = 1'h1;
        place_code  = code;
        @(negedge MCLK);
        place_valid = 1'h0;
        place_code  = ~code;
    endtask

    // Idle cycles first, so a slow core still leaves the answer visible
    task automatic access(input logic [ADDR_W-1:0] a,
                          input int idle);
        repeat (idle) @(negedge MCLK);
        acc_valid = 1'h1;
        acc_addr  = a;
        @(negedge MCLK);
        acc_valid = 1'h0;
        acc_addr  = ~a;
    endtask
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ns
module tb
    import mmdec_pkg::*;
;
    typedef struct packed {
        logic [1:0]        mode;
        logic [ADDR_W-1:0] addr;
        mmdec_target_t     tgt;
    } mmdec_row_t;
    logic              MCLK = 1'h0;
    logic              RST = 1'h1;
    logic              EXP_MODE = 1'h0;
    logic              PLACE_VALID, ACC_VALID, PLACED, HIGH_PLACE;
    logic              RES_VALID, VECTOR_HIT;
    logic [3:0]        PLACE_CODE;
    logic [ADDR_W-1:0] ACC_ADDR;
    mmdec_result_t     RESULT, exp_r;
    mmdec_result_t     RESULT_S, RESULT_M;
    int                fails = 0;
    int                n_checks = 0;
    // Mode bit 1 = high placement, bit 0 = expansion mode
    mmdec_row_t rows [18] = '{
        '{2'h0, 20'h00000, MMDEC_TGT_ROM}, '{2'h0, 20'h0deff, MMDEC_TGT_ROM},
        '{2'h0, 20'h0df00, MMDEC_TGT_DATA}, '{2'h0, 20'h0ff05, MMDEC_TGT_DATA},
        '{2'h1, 20'h0ffff, MMDEC_TGT_DATA}, '{2'h0, 20'h10000, MMDEC_TGT_ROM},
        '{2'h0, 20'h1ffff, MMDEC_TGT_ROM}, '{2'h1, 20'h20000, MMDEC_TGT_EXT},
        '{2'h0, 20'h20000, MMDEC_TGT_NONE}, '{2'h1, 20'hfdf00, MMDEC_TGT_EXT},
        '{2'h2, 20'h000ff, MMDEC_TGT_ROM}, '{2'h2, 20'h0df00, MMDEC_TGT_ROM},
        '{2'h2, 20'h1ffff, MMDEC_TGT_ROM}, '{2'h3, 20'hfdeff, MMDEC_TGT_EXT},
        '{2'h2, 20'hfdeff, MMDEC_TGT_NONE}, '{2'h2, 20'hfdf00, MMDEC_TGT_DATA},
        '{2'h3, 20'hfff00, MMDEC_TGT_DATA}, '{2'h3, 20'hfffff, MMDEC_TGT_DATA}};

    always #2 MCLK = ~MCLK;

    mmdec_cpu_model i_cpu (.MCLK(MCLK), .place_valid(PLACE_VALID),
        .place_code(PLACE_CODE), .acc_valid(ACC_VALID), .acc_addr(ACC_ADDR));
    mmdec_top i_dut (.MCLK(MCLK), .RST(RST), .PLACE_VALID(PLACE_VALID),
        .PLACE_CODE(PLACE_CODE), .EXP_MODE(EXP_MODE), .ACC_VALID(ACC_VALID),
        .ACC_ADDR(ACC_ADDR), .PLACED(PLACED), .HIGH_PLACE(HIGH_PLACE),
        .RES_VALID(RES_VALID), .RESULT(RESULT), .VECTOR_HIT(VECTOR_HIT));
    mmdec_top #(.VARIANT(MMDEC_SMALL)) i_dut_s (.MCLK(MCLK), .RST(RST),
        .PLACE_VALID(PLACE_VALID), .PLACE_CODE(PLACE_CODE),
        .EXP_MODE(EXP_MODE), .ACC_VALID(ACC_VALID), .ACC_ADDR(ACC_ADDR),
        .PLACED(), .HIGH_PLACE(), .RES_VALID(), .RESULT(RESULT_S),
        .VECTOR_HIT());
    mmdec_top #(.VARIANT(MMDEC_MIDDLE)) i_dut_m (.MCLK(MCLK), .RST(RST),
        .PLACE_VALID(PLACE_VALID), .PLACE_CODE(PLACE_CODE),
        .EXP_MODE(EXP_MODE), .ACC_VALID(ACC_VALID), .ACC_ADDR(ACC_ADDR),
        .PLACED(), .HIGH_PLACE(), .RES_VALID(), .RESULT(RESULT_M),
        .VECTOR_HIT());

    task automatic check(input string what, input logic [31:0] got,
                         input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic do_reset();
        @(negedge MCLK);
        RST = 1'h1;
        repeat (6) @(negedge MCLK);
        check("reset outs", {PLACED, HIGH_PLACE, RES_VALID, VECTOR_HIT,
                             RESULT}, 0);
        RST = 1'h0;
        $display("reset test done");
    endtask

    // Small and middle variants see the same stimulus as the main one
    task automatic check_var(input logic [ADDR_W-1:0] a,
                             input mmdec_target_t   ts,
                             input mmdec_target_t   tm);
        i_cpu.access(a, 1);
        check("small target", RESULT_S.target, ts);
        check("middle target", RESULT_M.target, tm);
    endtask

    initial begin
        do_reset();
        i_cpu.place(PLACE_LOW_CODE);
        check("low placed", {PLACED, HIGH_PLACE}, 2'h2);
        foreach (rows[i]) begin
            if (rows[i].mode[1] && !HIGH_PLACE) begin
                // Mid-run reset, then a late second placement must be ignored
                do_reset();
                i_cpu.place(PLACE_HIGH_CODE);
                i_cpu.place(PLACE_LOW_CODE);
                check("high kept", {PLACED, HIGH_PLACE}, 2'h3);
            end
            EXP_MODE = rows[i].mode[0];
            exp_r.target = rows[i].tgt;
            exp_r.sfr = rows[i].tgt == MMDEC_TGT_DATA && rows[i].addr >=
                        (rows[i].mode[1] ? SFR_HI_BASE : SFR_LO_BASE);
            exp_r.offset = rows[i].addr - ((rows[i].tgt != MMDEC_TGT_DATA) ?
                20'h0 : rows[i].mode[1] ? DATA_HI_LARGE : DATA_LO_LARGE);
            // One idle cycle at least, so valid never toggles in one step
            i_cpu.access(rows[i].addr, 1 + i % 3);
            check("result", {RES_VALID, RESULT}, {1'h1, exp_r});
            check("target", RESULT.target, rows[i].tgt);
            check("vector", VECTOR_HIT, rows[i].addr <= VECTOR_END);
            $display("row %0d done", i);
        end
        // Access ended last cycle: valid and vector flag must drop
        @(negedge MCLK);
        check("idle flags", {RES_VALID, VECTOR_HIT}, 2'h0);
        // Size variants, high placement still in force
        EXP_MODE = 1'h0;
        check_var(DATA_HI_SMALL, MMDEC_TGT_DATA, MMDEC_TGT_DATA);
        check_var(DATA_HI_MIDDLE, MMDEC_TGT_NONE, MMDEC_TGT_DATA);
        check_var(DATA_LO_SMALL, MMDEC_TGT_ROM, MMDEC_TGT_ROM);
        check_var(ROM_END_SMALL + 20'h1, MMDEC_TGT_NONE, MMDEC_TGT_ROM);
        do_reset();
        i_cpu.place(PLACE_LOW_CODE);
        check_var(DATA_LO_SMALL, MMDEC_TGT_DATA, MMDEC_TGT_DATA);
        check_var(DATA_LO_MIDDLE, MMDEC_TGT_ROM, MMDEC_TGT_DATA);
        check_var(DATA_LO_SMALL - 20'h1, MMDEC_TGT_ROM, MMDEC_TGT_DATA);
        check_var(ROM2_BASE, MMDEC_TGT_ROM, MMDEC_TGT_ROM);
        check_var(ROM_END_SMALL + 20'h1, MMDEC_TGT_NONE, MMDEC_TGT_ROM);
        $display("variant test done");
        print_verdict();
    end

    initial begin
        repeat (10000) @(posedge MCLK);
        fails++;
        print_verdict();
    end
endmodule
